// ---- common/epiu_pkg.sv ----
// package: register map, sense encodings, vectors and reset values
package epiu_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets on the plain register port
   localparam logic [7:0] EPIU_OFF_SENSE    = 8'h00;
   localparam logic [7:0] EPIU_OFF_DMASK    = 8'h01;
   localparam logic [7:0] EPIU_OFF_DFLAG    = 8'h02;
   localparam logic [7:0] EPIU_OFF_BENABLE  = 8'h03;
   localparam logic [7:0] EPIU_OFF_BFLAG    = 8'h04;
   localparam logic [7:0] EPIU_OFF_UMASK    = 8'h05;
   localparam logic [7:0] EPIU_OFF_LMASK    = 8'h06;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int EPIU_FIRST_SENSE_LSB  = 0;
   localparam int EPIU_SECOND_SENSE_LSB = 2;
   localparam int EPIU_SENSE_W          = 4;
   localparam int EPIU_PAIR_W           = 2;
   localparam int EPIU_BANK_W           = 8;
   localparam int EPIU_PC_W             = 16;
   localparam int EPIU_IRQ_N            = 4;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [3:0] EPIU_RST_SENSE = 4'h0;
   localparam logic [1:0] EPIU_RST_PAIR  = 2'h0;
   localparam logic [7:0] EPIU_RST_BYTE  = 8'h00;
   localparam logic       EPIU_RST_SYNC  = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // vector word addresses
   localparam logic [15:0] EPIU_VEC_RESET = 16'h0000;
   localparam logic [15:0] EPIU_VEC_FIRST_DEDICATED_IRQ_PIN  = 16'h0002;
   localparam logic [15:0] EPIU_VEC_SECOND_DEDICATED_IRQ_PIN  = 16'h0004;
   localparam logic [15:0] EPIU_VEC_PC0   = 16'h0006;
   localparam logic [15:0] EPIU_VEC_PC1   = 16'h0008;

   ////////////////////////////////////////////////////////////////////////
   // sense field encoding
   typedef enum logic [1:0] {
      EPIU_SENSE_LOW  = 2'b00,
      EPIU_SENSE_ANY  = 2'b01,
      EPIU_SENSE_FALL = 2'b10,
      EPIU_SENSE_RISE = 2'b11
   } epiu_sense_e;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } epiu_bus_s;

endpackage

// ---- design/epiu_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module epiu_pin_sync
   import epiu_pkg::*;
#(
   parameter int WIDTH = 18
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_raw,
   // filtered value and change strobe
   output logic      [WIDTH-1:0] val_q,
   output logic      [WIDTH-1:0] chg
);

   ////////////////////////////////////////////////////////////////////////
   // one filter per pin
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic v_q;
         // change counts once stages two and three agree
         assign chg[g]   = (s2_q == s3_q) && (s3_q != v_q);
         assign val_q[g] = v_q;
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               s1_q <= EPIU_RST_SYNC;
               s2_q <= EPIU_RST_SYNC;
               s3_q <= EPIU_RST_SYNC;
               v_q  <= EPIU_RST_SYNC;
            end else begin
               s1_q <= pin_raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               v_q  <= chg[g] ? s3_q : v_q;
            end
         end
      end
   endgenerate

endmodule // epiu_pin_sync
`default_nettype wire

// ---- design/epiu_sense.sv ----
// sense decode for one dedicated interrupt pin
`timescale 1ns/10ps
`default_nettype none
module epiu_sense
   import epiu_pkg::*;
(
   // configuration
   input  wire logic        enabled,
   input  wire epiu_sense_e mode,
   // pin views
   input  wire logic        pin_raw,
   input  wire logic        val_q,
   input  wire logic        chg,
   // results
   output logic             trig,
   output logic             level_act,
   output logic             level_wake
);

   ////////////////////////////////////////////////////////////////////////
   // edge recognition from filtered samples, clocked path only
   wire any_hit  = (mode == EPIU_SENSE_ANY);
   wire fall_hit = (mode == EPIU_SENSE_FALL) && val_q;
   wire rise_hit = (mode == EPIU_SENSE_RISE) && !val_q;
   assign trig = chg && (any_hit || fall_hit || rise_hit);

   // level request follows the filtered pin while low
   assign level_act = (mode == EPIU_SENSE_LOW) && !val_q;

   // level wake straight from the pad, no clock needed
   assign level_wake = enabled && (mode == EPIU_SENSE_LOW) && !pin_raw;

endmodule // epiu_sense
`default_nettype wire

// ---- design/epiu_top.sv ----
// external pin interrupt unit: registers, flags, requests and wake
`timescale 1ns/10ps
`default_nettype none
module epiu_top
   import epiu_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // register port
   input  wire epiu_bus_s   bus,
   output logic      [7:0]  rdata_q,
   // pads
   input  wire logic [1:0]  dedicated_irq_pins,
   input  wire logic [15:0] pin_change_inputs,
   // core interface
   input  wire logic        global_irq_en,
   input  wire logic [3:0]  irq_ack,
   output logic      [3:0]  irq_req,
   output logic      [15:0] irq_vector_q,
   // power controller
   output logic             wake_req
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] sense_q;
   logic [3:0] sense_d;
   logic [1:0] dmask_q;
   logic [1:0] dmask_d;
   logic [1:0] dflag_q;
   logic [1:0] dflag_d;
   logic [1:0] benable_q;
   logic [1:0] benable_d;
   logic [1:0] bflag_q;
   logic [1:0] bflag_d;
   logic [7:0] umask_q;
   logic [7:0] umask_d;
   logic [7:0] lmask_q;
   logic [7:0] lmask_d;
   logic [7:0] rdata_d;
   logic [15:0] vec_d;

   ////////////////////////////////////////////////////////////////////////
   // synchronisers: pads are read whatever their direction
   logic [17:0] pin_all;
   logic [17:0] val_q;
   logic [17:0] chg;
   assign pin_all = {dedicated_irq_pins, pin_change_inputs};

   epiu_pin_sync #(
      .WIDTH (18)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_raw (pin_all),
      .val_q   (val_q),
      .chg     (chg)
   );

   ////////////////////////////////////////////////////////////////////////
   // dedicated pin sense decode
   epiu_sense_e mode0;
   epiu_sense_e mode1;
   logic [1:0]  trig;
   logic [1:0]  level_act;
   logic [1:0]  level_wake;
   // field placement
   assign mode0 = epiu_sense_e'(sense_q[EPIU_FIRST_SENSE_LSB +: 2]);
   assign mode1 = epiu_sense_e'(sense_q[EPIU_SECOND_SENSE_LSB +: 2]);

   epiu_sense u_sense0 (
      .enabled    (dmask_q[0]),
      .mode       (mode0),
      .pin_raw    (dedicated_irq_pins[0]),
      .val_q      (val_q[16]),
      .chg        (chg[16]),
      .trig       (trig[0]),
      .level_act  (level_act[0]),
      .level_wake (level_wake[0])
   );

   epiu_sense u_sense1 (
      .enabled    (dmask_q[1]),
      .mode       (mode1),
      .pin_raw    (dedicated_irq_pins[1]),
      .val_q      (val_q[17]),
      .chg        (chg[17]),
      .trig       (trig[1]),
      .level_act  (level_act[1]),
      .level_wake (level_wake[1])
   );

   ////////////////////////////////////////////////////////////////////////
   // address decode
   wire wr_sense = bus.wr && (bus.addr == EPIU_OFF_SENSE);
   wire wr_dmask = bus.wr && (bus.addr == EPIU_OFF_DMASK);
   wire wr_dflag = bus.wr && (bus.addr == EPIU_OFF_DFLAG);
   wire wr_ben   = bus.wr && (bus.addr == EPIU_OFF_BENABLE);
   wire wr_bflag = bus.wr && (bus.addr == EPIU_OFF_BFLAG);
   wire wr_umask = bus.wr && (bus.addr == EPIU_OFF_UMASK);
   wire wr_lmask = bus.wr && (bus.addr == EPIU_OFF_LMASK);

   ////////////////////////////////////////////////////////////////////////
   // control register next values
   assign sense_d   = wr_sense ? bus.wdata[3:0] : sense_q;
   assign dmask_d   = wr_dmask ? bus.wdata[1:0] : dmask_q;
   assign benable_d = wr_ben   ? bus.wdata[1:0] : benable_q;
   assign umask_d   = wr_umask ? bus.wdata     : umask_q;
   assign lmask_d   = wr_lmask ? bus.wdata     : lmask_q;

   ////////////////////////////////////////////////////////////////////////
   // dedicated flags: set wins over clear, held low in level mode
   wire [1:0] dclr  = (wr_dflag ? bus.wdata[1:0] : 2'h0) | irq_ack[1:0];
   wire [1:0] dlvl  = {mode1 == EPIU_SENSE_LOW, mode0 == EPIU_SENSE_LOW};
   assign dflag_d = ~dlvl & (trig | (dflag_q & ~dclr));

   ////////////////////////////////////////////////////////////////////////
   // pin-change banks: masked toggles set the bank flag
   wire lchg = |(chg[7:0] & lmask_q);
   wire uchg = |(chg[15:8] & umask_q);
   wire [1:0] bset = {uchg, lchg};
   wire [1:0] bclr = (wr_bflag ? bus.wdata[1:0] : 2'h0) | irq_ack[3:2];
   assign bflag_d = bset | (bflag_q & ~bclr);

   ////////////////////////////////////////////////////////////////////////
   // requests toward the core
   // level mode requests from the filtered level, so a level that is
   // gone before start-up ends raises no request
   wire [1:0] dsrc = (dlvl & level_act) | (~dlvl & dflag_q);
   assign irq_req[1:0] = {2{global_irq_en}} & dmask_q & dsrc;
   assign irq_req[3:2] = {2{global_irq_en}} & benable_q & bflag_q;

   // vector of the highest priority request
   assign vec_d = irq_req[0] ? EPIU_VEC_FIRST_DEDICATED_IRQ_PIN :
                  irq_req[1] ? EPIU_VEC_SECOND_DEDICATED_IRQ_PIN :
                  irq_req[2] ? EPIU_VEC_PC0  :
                  irq_req[3] ? EPIU_VEC_PC1  : EPIU_VEC_RESET;

   ////////////////////////////////////////////////////////////////////////
   // asynchronous wake: pads against last filtered value
   wire [15:0] pc_mask = {umask_q & {8{benable_q[1]}},
                          lmask_q & {8{benable_q[0]}}};
   wire pc_wake = |((pin_change_inputs ^ val_q[15:0]) & pc_mask);
   assign wake_req = pc_wake || (|level_wake);

   ////////////////////////////////////////////////////////////////////////
   // read mux, reserved bits read zero
   logic [7:0] rd_mux;
   always_comb begin
      unique case (bus.addr)
         EPIU_OFF_SENSE:   rd_mux = {4'h0, sense_q};
         EPIU_OFF_DMASK:   rd_mux = {6'h00, dmask_q};
         EPIU_OFF_DFLAG:   rd_mux = {6'h00, dflag_q};
         EPIU_OFF_BENABLE: rd_mux = {6'h00, benable_q};
         EPIU_OFF_BFLAG:   rd_mux = {6'h00, bflag_q};
         EPIU_OFF_UMASK:   rd_mux = umask_q;
         EPIU_OFF_LMASK:   rd_mux = lmask_q;
         default:          rd_mux = 8'h00;
      endcase
   end
   assign rdata_d = bus.rd ? rd_mux : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sense_q      <= EPIU_RST_SENSE;
         dmask_q      <= EPIU_RST_PAIR;
         dflag_q      <= EPIU_RST_PAIR;
         benable_q    <= EPIU_RST_PAIR;
         bflag_q      <= EPIU_RST_PAIR;
         umask_q      <= EPIU_RST_BYTE;
         lmask_q      <= EPIU_RST_BYTE;
         rdata_q      <= EPIU_RST_BYTE;
         irq_vector_q <= EPIU_VEC_RESET;
      end else begin
         sense_q      <= sense_d;
         dmask_q      <= dmask_d;
         dflag_q      <= dflag_d;
         benable_q    <= benable_d;
         bflag_q      <= bflag_d;
         umask_q      <= umask_d;
         lmask_q      <= lmask_d;
         rdata_q      <= rdata_d;
         irq_vector_q <= vec_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic rd_sense_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_sense_q <= 1'b0;
      end else begin
         rd_sense_q <= bus.rd && (bus.addr == EPIU_OFF_SENSE);
      end
   end

   AST_SENSE_RSVD: assert property (
      rd_sense_q |-> (rdata_q[7:4] == 4'h0) && (rdata_q[3:0] == sense_q)
   ) else $error("sense register read back wrong");

   AST_LEVEL_NOFLAG: assert property (
      (mode0 == EPIU_SENSE_LOW) && !wr_sense |=> !dflag_q[0]
   ) else $error("first pin flag set in level mode");

   AST_REQ_GATE: assert property (
      irq_req[1] |-> global_irq_en && dmask_q[1]
   ) else $error("dedicated request without enables");

   AST_LEVEL_HOLD: assert property (
      global_irq_en && dmask_q[0] && (mode0 == EPIU_SENSE_LOW) &&
      !val_q[16] |-> irq_req[0]
   ) else $error("level request missing while pin low");

   AST_LOWER_SET: assert property (
      |(chg[7:0] & lmask_q) |=> bflag_q[0]
   ) else $error("lower bank flag not set on change");

   AST_UPPER_SET: assert property (
      |(chg[15:8] & umask_q) |=> bflag_q[1]
   ) else $error("upper bank flag not set on change");

   AST_MASK_IGNORE: assert property (
      !bflag_q[0] && !(|(chg[7:0] & lmask_q)) |=> !bflag_q[0]
   ) else $error("masked pin set lower bank flag");

   AST_BANK_GATE: assert property (
      irq_req[3] |-> global_irq_en && benable_q[1] && bflag_q[1]
   ) else $error("bank request without enables");

   AST_FALL_EDGE: assert property (
      (mode1 == EPIU_SENSE_FALL) && chg[17] && val_q[17] &&
      !wr_sense |=> dflag_q[1]
   ) else $error("falling edge not flagged");

   AST_PC_WAKE: assert property (
      lmask_q[3] && benable_q[0] &&
      (pin_change_inputs[3] != val_q[3]) |-> wake_req
   ) else $error("pin change wake missing");

   AST_VECTOR: assert property (
      irq_req[2] && !irq_req[1] && !irq_req[0] |=>
      irq_vector_q == EPIU_VEC_PC0
   ) else $error("vector not for first bank");

   AST_SYNC_DELAY: assert property (
      $rose(val_q[16]) |-> $past(chg[16])
   ) else $error("filtered value changed without strobe");

   AST_UPPER_IGNORE: assert property (
      !bflag_q[1] && !(|(chg[15:8] & umask_q)) |=> !bflag_q[1]
   ) else $error("masked pin set upper bank flag");

   AST_LOWER_GATE: assert property (
      irq_req[2] |-> global_irq_en && benable_q[0] && bflag_q[0]
   ) else $error("lower bank request without enables");

   AST_ACK_CLEAR: assert property (
      dflag_q[1] && irq_ack[1] && !trig[1] |=> !dflag_q[1]
   ) else $error("second pin flag kept after handler");

   AST_BANK_CLEAR: assert property (
      bflag_q[0] && wr_bflag && bus.wdata[0] && !lchg |=> !bflag_q[0]
   ) else $error("lower bank flag kept after write one");

   AST_LEVEL_WAKE: assert property (
      dmask_q[1] && (mode1 == EPIU_SENSE_LOW) &&
      !dedicated_irq_pins[1] |-> wake_req
   ) else $error("level wake missing while pin low");

   AST_RISE_EDGE: assert property (
      (mode0 == EPIU_SENSE_RISE) && chg[16] && !val_q[16] |=> dflag_q[0]
   ) else $error("rising edge not flagged");

   COV_FALL_FLAG: cover property ($rose(dflag_q[1]));
   COV_LEVEL_REQ: cover property ($rose(irq_req[0]) && level_act[0]);
   COV_BANK_REQ:  cover property ($rose(irq_req[3]));
   COV_WAKE:      cover property ($rose(wake_req));

endmodule // epiu_top
`default_nettype wire

// ---- verif/epiu_core_model.sv ----
// core-side partner: acknowledges the highest-priority request
`timescale 1ns/10ps
`default_nettype none
module epiu_core_model
   import epiu_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // control from the bench
   input  wire logic       ack_en,
   input  wire logic [1:0] ack_lat,
   // requests and handler pulses
   input  wire logic [3:0] irq_req,
   output logic      [3:0] irq_ack
);
   logic [1:0] wait_q;

   ////////////////////////////////////////////////////////////////////////
   // handler execution after a prompt or slow delay
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !ack_en || irq_req == 4'h0 || irq_ack != 4'h0) begin
         wait_q  <= 2'h0;
         irq_ack <= 4'h0;
      end else if (wait_q < ack_lat) begin
         wait_q <= wait_q + 2'h1;
      end else begin
         irq_ack <= irq_req & (~irq_req + 4'h1);
      end
   end
endmodule // epiu_core_model
`default_nettype wire

// ---- verif/epiu_top_test.sv ----
// self-checking bench with a behavioural model of the unit
`timescale 1ns/10ps
`default_nettype none
module epiu_external_pin_interrupt_unit_test;
   import epiu_pkg::*;
   logic        clk_sys;
   logic        rst_n;
   epiu_bus_s   bus;
   logic [7:0]  rdata_q;
   logic [1:0]  dedicated_irq_pins;
   logic [15:0] pin_change_inputs;
   logic        global_irq_en;
   logic [3:0]  irq_ack;
   logic [3:0]  irq_req;
   logic [15:0] irq_vector_q;
   logic        wake_req;
   logic        ack_en;
   logic [1:0]  ack_lat;
   int          failures;
   int          cmp_count;
   int          cycles;
   int          m_reg[8];
   int          m_flag[4];
   logic [1:0]  f_ded;
   logic [15:0] f_pc;
   int          acking;
   int          k;

   epiu_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
      .rdata_q(rdata_q), .dedicated_irq_pins(dedicated_irq_pins),
      .pin_change_inputs(pin_change_inputs), .global_irq_en(global_irq_en),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector_q(irq_vector_q),
      .wake_req(wake_req));
   epiu_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .ack_en(ack_en),
      .ack_lat(ack_lat), .irq_req(irq_req), .irq_ack(irq_ack));

   ////////////////////////////////////////////////////////////////////////
   // verdict and comparisons
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic note(input bit ok, input string what);
      cmp_count++;
      if (!ok) begin
         failures++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic chk_req(input logic [3:0] g, input logic [3:0] e);
      note(g === e, $sformatf("request %h, expected %h", g, e));
   endtask
   task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
      note(g === e, $sformatf("read %h, expected %h", g, e));
   endtask
   task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
      note(g === e, $sformatf("vector %h, expected %h", g, e));
   endtask
   task automatic chk_wake(input logic g, input logic e);
      note(g === e, $sformatf("wake %b, expected %b", g, e));
   endtask

   ////////////////////////////////////////////////////////////////////////
   // behavioural model
   function automatic logic [3:0] exp_req();
      logic [3:0] r;
      for (int i = 0; i < 2; i++) begin
         r[i] = global_irq_en && m_reg[1][i] && ((((m_reg[0] >> (2 * i)) & 3)
                == 0) ? !f_ded[i] : m_flag[i] != 0);
         r[i + 2] = global_irq_en && m_reg[3][i] && m_flag[i + 2] != 0;
      end
      return r;
   endfunction
   function automatic logic [15:0] exp_vec();
      logic [3:0] r;
      r = exp_req();
      if (r[0]) return EPIU_VEC_FIRST_DEDICATED_IRQ_PIN;
      if (r[1]) return EPIU_VEC_SECOND_DEDICATED_IRQ_PIN;
      if (r[2]) return EPIU_VEC_PC0;
      if (r[3]) return EPIU_VEC_PC1;
      return EPIU_VEC_RESET;
   endfunction
   function automatic logic [7:0] exp_rd(input int a);
      case (a)
         0: return 8'(m_reg[0] & 15);
         1, 3: return 8'(m_reg[a] & 3);
         2: return 8'(m_flag[0] | (m_flag[1] << 1));
         4: return 8'(m_flag[2] | (m_flag[3] << 1));
         5, 6: return 8'(m_reg[a] & 255);
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic exp_wake(input logic [1:0] d, input logic [15:0] p);
      logic w;
      w = 1'b0;
      for (int i = 0; i < 16; i++)
         if (p[i] != f_pc[i] && m_reg[6 - i / 8][i % 8] && m_reg[3][i / 8])
            w = 1'b1;
      for (int i = 0; i < 2; i++)
         if (m_reg[1][i] && ((m_reg[0] >> (2 * i)) & 3) == 0 && !d[i])
            w = 1'b1;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register port and pad drivers
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
      if (a == EPIU_OFF_DFLAG || a == EPIU_OFF_BFLAG)
         for (int i = 0; i < 2; i++)
            if (d[i]) m_flag[i + 2 * (a / 4)] = 0;
      if (a < 8'h07 && a != EPIU_OFF_DFLAG && a != EPIU_OFF_BFLAG) m_reg[a] = d;
      for (int i = 0; i < 2; i++)
         if (((m_reg[0] >> (2 * i)) & 3) == 0) m_flag[i] = 0;
      @(posedge clk_sys);
   endtask
   task automatic rd_chk(input logic [7:0] a);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1 chk_rd(rdata_q, exp_rd(a));
      @(posedge clk_sys);
   endtask
   // pads may be outputs elsewhere: they are driven here all the same
   task automatic pins(input logic [1:0] d, input logic [15:0] p, input int n);
      int s;
      dedicated_irq_pins <= d;
      pin_change_inputs  <= p;
      #1 chk_wake(wake_req, exp_wake(d, p));
      for (int i = 0; i < 2; i++) begin
         s = (m_reg[0] >> (2 * i)) & 3;
         if (d[i] != f_ded[i] && (s == 1 || s == 2 && !d[i] || s == 3 && d[i]))
            m_flag[i] = 1;
      end
      for (int i = 0; i < 16; i++)
         if (p[i] != f_pc[i] && m_reg[6 - i / 8][i % 8]) m_flag[2 + i / 8] = 1;
      if (acking != 0) for (int i = 0; i < 4; i++) m_flag[i] = 0;
      f_ded = d;
      f_pc  = p;
      repeat (n) @(posedge clk_sys);
      if (n >= 6) begin
         #1;
         chk_req(irq_req, exp_req());
         chk_vec(irq_vector_q, exp_vec());
         @(posedge clk_sys);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock, timeout and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      rst_n = 1'b0;
      bus = '0;
      dedicated_irq_pins = 2'h3;
      pin_change_inputs = 16'hffff;
      global_irq_en = 1'b1;
      ack_en = 1'b0;
      ack_lat = 2'h0;
      f_ded = 2'h3;
      f_pc = 16'hffff;
      acking = 0;
      foreach (m_reg[i]) m_reg[i] = 0;
      foreach (m_flag[i]) m_flag[i] = 0;
      void'($urandom(6));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (k = 0; k < 8; k++) rd_chk(8'(k));
      for (k = 0; k < 8; k++) reg_wr(8'(k), 8'hff);
      for (k = 0; k < 8; k++) rd_chk(8'(k));
      for (k = 0; k < 8; k++) begin
         reg_wr(EPIU_OFF_SENSE, 8'((k / 2) << (2 * (k % 2))));
         pins(2'h3 ^ 2'(1 << (k % 2)), pin_change_inputs, 6);
         rd_chk(EPIU_OFF_DFLAG);
         pins(2'h3, pin_change_inputs, 6);
         rd_chk(EPIU_OFF_DFLAG);
         reg_wr(EPIU_OFF_DFLAG, 8'h03);
      end
      reg_wr(EPIU_OFF_SENSE, 8'h01);
      pins(2'h2, pin_change_inputs, 3);
      pins(2'h3, pin_change_inputs, 6);
      reg_wr(EPIU_OFF_SENSE, 8'h02);
      pins(2'h2, pin_change_inputs, 6);
      global_irq_en <= 1'b0;
      #1 chk_req(irq_req, exp_req());
      @(posedge clk_sys);
      reg_wr(EPIU_OFF_DMASK, 8'h02);
      global_irq_en <= 1'b1;
      #1 chk_req(irq_req, exp_req());
      @(posedge clk_sys);
      reg_wr(EPIU_OFF_DMASK, 8'h03);
      reg_wr(EPIU_OFF_DFLAG, 8'h01);
      pins(2'h3, pin_change_inputs, 6);
      reg_wr(EPIU_OFF_SENSE, 8'h08);
      ack_en <= 1'b1;
      ack_lat <= 2'($urandom_range(3));
      acking = 1;
      pins(2'h1, pin_change_inputs, 12);
      rd_chk(EPIU_OFF_DFLAG);
      ack_en <= 1'b0;
      acking = 0;
      reg_wr(EPIU_OFF_SENSE, 8'h00);
      pins(2'h3, pin_change_inputs, 6);
      for (k = 0; k < 16; k++) begin
         reg_wr(EPIU_OFF_LMASK, 8'($urandom));
         reg_wr(EPIU_OFF_UMASK, 8'($urandom));
         pins(2'h3, 16'($urandom), 6);
         rd_chk(EPIU_OFF_BFLAG);
         reg_wr(EPIU_OFF_BFLAG, 8'h03);
      end
      pins(2'h2, pin_change_inputs, 1);
      pins(2'h3, pin_change_inputs, 6);
      pins(2'h2, pin_change_inputs, 6);
      pins(2'h3, pin_change_inputs, 6);
      complete_run();
   end
endmodule // epiu_external_pin_interrupt_unit_test
`default_nettype wire
